// ===== core/sar_adc_pkg.sv
// package: register map, field positions and timing for the sar sequencer
package sar_adc_pkg;
   // register byte addresses (word aligned)
   localparam logic [3:0] MAIN_CTRL_ADDR = 4'h0;
   localparam logic [3:0] TIMING_CTRL_ADDR = 4'h4;
   localparam logic [3:0] RESULT_HIGH_ADDR = 4'h8;
   localparam logic [3:0] RESULT_LOW_ADDR = 4'hc;
   // field positions
   localparam int ENABLE_BIT = 0;
   localparam int START_BIT = 1;
   localparam int DONE_FLAG_BIT = 7;
   localparam int JUSTIFY_BIT = 7;
   localparam int ACQ_LSB = 3;
   localparam int CLK_LSB = 0;
   // reset values
   localparam logic [7:0] MAIN_CTRL_RESET = 8'h00;
   localparam logic [7:0] TIMING_CTRL_RESET = 8'h00;
   // timing: conversion in bit periods, rc start delay in clock cycles
   localparam int CONV_PERIODS = 11;
   localparam int RC_START_DELAY = 4;
   localparam int RESULT_BITS = 10;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DELAY = 2'b01,
      ST_ACQUIRE = 2'b10,
      ST_CONVERT = 2'b11
   } seq_state_type;

   typedef struct packed {
      logic justifyRight;
      logic [2:0] acquireTimeSel;
      logic [2:0] convClockSel;
   } timing_type;
endpackage

// ===== core/sar_adc_sequencer.sv
// sar converter sequencer with wishbone register slave
`timescale 1ns/100ps
// Summary of operation
// - format bit set means right justified
// - acquire code picks 20..0 bit periods
// - clock code picks divider or rc clock
// - rc clock start delayed one instruction
// - sleep conversion needs rc clock source
// - one result bit per bit period
// - reset clears control registers and aborts conversion
// - done writes result, clears start, sets flag
// - result bytes have no reset value
// - sampling switch opens as conversion begins
// - nonzero acquire code times sampling automatically
// - acquire code zero converts at once
// - sampling resumes after every conversion
// - start bit stays set through both phases
// - bit six reads zero, ignores writes
// - enable bit zero, start bit one
// - conversion takes eleven bit periods
// - clearing start aborts, result unchanged
module sar_adc_sequencer #(
   parameter int DIV_MAX = 64,
   parameter int RC_DIV = 500
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic compareHigh,
   output logic sampleSwitch,
   output logic [sar_adc_pkg::RESULT_BITS-1:0] trialCode,
   output logic converterPowered,
   output logic conversionDoneFlag
);
   // tick counter is ten bits wide
   if (DIV_MAX < 64 || DIV_MAX > 1024 || RC_DIV < 2
      || RC_DIV > 1023) begin : g_bad_divider
      $error("sar_adc_sequencer: divider parameters out of range");
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic converterEnable;
   logic startBusy;
   sar_adc_pkg::timing_type timing;
   logic [7:0] resultHigh;
   logic [7:0] resultLow;
   sar_adc_pkg::seq_state_type state;
   logic [9:0] tickCount;
   logic tick;
   logic [4:0] periodCount;
   logic [9:0] sarValue;
   logic [3:0] bitIndex;
   logic done;

   wire logic access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // writes land at the edge where the master sees ack
   wire logic commit = wb_cyc_i && wb_stb_i && wb_ack_o;
   wire logic writeMain = commit && wb_we_i && wb_sel_i[0]
      && wb_adr_i == sar_adc_pkg::MAIN_CTRL_ADDR;
   wire logic writeTiming = commit && wb_we_i && wb_sel_i[0]
      && wb_adr_i == sar_adc_pkg::TIMING_CTRL_ADDR;
   wire logic writeHigh = commit && wb_we_i && wb_sel_i[0]
      && wb_adr_i == sar_adc_pkg::RESULT_HIGH_ADDR;
   wire logic writeLow = commit && wb_we_i && wb_sel_i[0]
      && wb_adr_i == sar_adc_pkg::RESULT_LOW_ADDR;
   wire logic isRc = timing.convClockSel[1:0] == 2'b11;

   function automatic logic [4:0] acquirePeriods(input logic [2:0] code);
      case (code)
         3'h7: acquirePeriods = 5'd20;
         3'h6: acquirePeriods = 5'd16;
         3'h5: acquirePeriods = 5'd12;
         3'h4: acquirePeriods = 5'd8;
         3'h3: acquirePeriods = 5'd6;
         3'h2: acquirePeriods = 5'd4;
         3'h1: acquirePeriods = 5'd2;
         default: acquirePeriods = 5'd0;
      endcase
   endfunction

   function automatic logic [9:0] clockDivide(input logic [2:0] code);
      case (code)
         3'h0: clockDivide = 10'd2;
         3'h1: clockDivide = 10'd8;
         3'h2: clockDivide = 10'd32;
         3'h4: clockDivide = 10'd4;
         3'h5: clockDivide = 10'd16;
         3'h6: clockDivide = 10'd64;
         default: clockDivide = 10'(RC_DIV);
      endcase
   endfunction

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= access;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_dat_o <= 32'h0;
      end else if (access) begin
         case (wb_adr_i)
            sar_adc_pkg::MAIN_CTRL_ADDR:
               wb_dat_o <= {24'h0, conversionDoneFlag, 5'h0, startBusy,
                  converterEnable};
            sar_adc_pkg::TIMING_CTRL_ADDR:
               wb_dat_o <= {24'h0, timing.justifyRight, 1'b0,
                  timing.acquireTimeSel, timing.convClockSel};
            sar_adc_pkg::RESULT_HIGH_ADDR:
               wb_dat_o <= {24'h0, resultHigh};
            sar_adc_pkg::RESULT_LOW_ADDR:
               wb_dat_o <= {24'h0, resultLow};
            default:
               wb_dat_o <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timing <= '0;
      end else if (writeTiming) begin
         timing <= {wb_dat_i[7], wb_dat_i[5:0]};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         converterEnable <= 1'b0;
      end else if (writeMain) begin
         converterEnable <= wb_dat_i[sar_adc_pkg::ENABLE_BIT];
      end
   end

   // start bit: software sets/clears, hardware clears on done
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         startBusy <= 1'b0;
      end else if (done) begin
         startBusy <= 1'b0;
      end else if (writeMain) begin
         startBusy <= wb_dat_i[sar_adc_pkg::START_BIT]
            && wb_dat_i[sar_adc_pkg::ENABLE_BIT];
      end else if (!converterEnable) begin
         startBusy <= 1'b0;
      end
   end

   // done flag: set wins over a software clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conversionDoneFlag <= 1'b0;
      end else if (done) begin
         conversionDoneFlag <= 1'b1;
      end else if (writeMain && !wb_dat_i[sar_adc_pkg::DONE_FLAG_BIT]) begin
         conversionDoneFlag <= 1'b0;
      end
   end

   // result bytes carry no reset
   always_ff @(posedge clk) begin
      if (done) begin
         if (timing.justifyRight) begin
            resultHigh <= {6'h0, sarValue[9:8]};
            resultLow <= sarValue[7:0];
         end else begin
            resultHigh <= sarValue[9:2];
            resultLow <= {sarValue[1:0], 6'h0};
         end
      end else begin
         if (writeHigh) begin
            resultHigh <= wb_dat_i[7:0];
         end
         if (writeLow) begin
            resultLow <= wb_dat_i[7:0];
         end
      end
   end

   // ----------------------------------------
   // conversion clock tick
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tickCount <= 10'h0;
         tick <= 1'b0;
      end else if (state == sar_adc_pkg::ST_IDLE
         || state == sar_adc_pkg::ST_DELAY) begin
         tickCount <= 10'h0;
         tick <= 1'b0;
      end else if (tickCount >= clockDivide(timing.convClockSel) - 10'd1) begin
         tickCount <= 10'h0;
         tick <= 1'b1;
      end else begin
         tickCount <= tickCount + 10'd1;
         tick <= 1'b0;
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= sar_adc_pkg::ST_IDLE;
         periodCount <= 5'h0;
         sarValue <= 10'h0;
         bitIndex <= 4'h0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         // no restart while the done pulse still sees start set
         if (!startBusy || !converterEnable || done) begin
            state <= sar_adc_pkg::ST_IDLE;
         end else begin
            case (state)
               sar_adc_pkg::ST_IDLE: begin
                  periodCount <= 5'h0;
                  if (isRc) begin
                     state <= sar_adc_pkg::ST_DELAY;
                  end else if (timing.acquireTimeSel == 3'h0) begin
                     state <= sar_adc_pkg::ST_CONVERT;
                     bitIndex <= 4'h0;
                     sarValue <= 10'h200;
                  end else begin
                     state <= sar_adc_pkg::ST_ACQUIRE;
                  end
               end
               sar_adc_pkg::ST_DELAY: begin
                  periodCount <= periodCount + 5'd1;
                  if (periodCount == 5'(sar_adc_pkg::RC_START_DELAY - 1)) begin
                     periodCount <= 5'h0;
                     state <= sar_adc_pkg::ST_ACQUIRE;
                  end
               end
               sar_adc_pkg::ST_ACQUIRE: begin
                  if (periodCount >= acquirePeriods(timing.acquireTimeSel)) begin
                     state <= sar_adc_pkg::ST_CONVERT;
                     bitIndex <= 4'h0;
                     sarValue <= 10'h200;
                  end else if (tick) begin
                     periodCount <= periodCount + 5'd1;
                  end
               end
               sar_adc_pkg::ST_CONVERT: begin
                  if (tick) begin
                     bitIndex <= bitIndex + 4'd1;
                     if (bitIndex >= 4'd1 && bitIndex <= 4'd10) begin
                        // keep or drop trial bit, try next
                        if (!compareHigh) begin
                           sarValue[4'd10 - bitIndex] <= 1'b0;
                        end
                        if (bitIndex < 4'd10) begin
                           sarValue[4'd9 - bitIndex] <= 1'b1;
                        end
                     end
                     if (bitIndex == 4'(sar_adc_pkg::CONV_PERIODS - 1)) begin
                        done <= 1'b1;
                        state <= sar_adc_pkg::ST_IDLE;
                     end
                  end
               end
               default: state <= sar_adc_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // sampling closed while enabled, except while converting
   assign sampleSwitch = converterEnable
      && state != sar_adc_pkg::ST_CONVERT;
   assign trialCode = sarValue;
   assign converterPowered = converterEnable;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_switch_open: assert property (@(posedge clk) disable iff (rst)
      state == sar_adc_pkg::ST_CONVERT |-> !sampleSwitch)
      else $error("sample switch closed during conversion");
   a_done_clears_start: assert property (@(posedge clk) disable iff (rst)
      done |=> !startBusy && conversionDoneFlag)
      else $error("done did not clear start or set flag");
   a_disabled_no_start: assert property (@(posedge clk) disable iff (rst)
      !converterEnable && !writeMain |=> !startBusy)
      else $error("start set while disabled");
   a_manual_immediate: assert property (@(posedge clk) disable iff (rst)
      state == sar_adc_pkg::ST_IDLE && startBusy && converterEnable && !isRc
      && timing.acquireTimeSel == 3'h0 && !done && !writeMain
      |=> state == sar_adc_pkg::ST_CONVERT)
      else $error("manual mode did not convert at once");
   a_bit6_zero: assert property (@(posedge clk) disable iff (rst)
      $rose(wb_ack_o) && $past(wb_adr_i) == sar_adc_pkg::TIMING_CTRL_ADDR
      |-> wb_dat_o[6] == 1'b0)
      else $error("reserved bit read nonzero");
   a_abort_keeps: assert property (@(posedge clk) disable iff (rst)
      state == sar_adc_pkg::ST_CONVERT && !startBusy
      |=> $stable(resultHigh) && state == sar_adc_pkg::ST_IDLE)
      else $error("abort changed result");
   a_auto_acquire: assert property (@(posedge clk) disable iff (rst)
      state == sar_adc_pkg::ST_IDLE && startBusy && converterEnable && !isRc
      && timing.acquireTimeSel != 3'h0 && !writeMain && !done
      |=> state == sar_adc_pkg::ST_ACQUIRE)
      else $error("auto acquisition skipped");
   a_start_held: assert property (@(posedge clk) disable iff (rst)
      state == sar_adc_pkg::ST_ACQUIRE && !writeMain && converterEnable
      |-> startBusy)
      else $error("start bit dropped during acquisition");
   a_rc_delay: assert property (@(posedge clk) disable iff (rst)
      state == sar_adc_pkg::ST_IDLE && startBusy && converterEnable && isRc
      && !writeMain && !done |=> state == sar_adc_pkg::ST_DELAY)
      else $error("rc delay skipped");
   c_manual: cover property (@(posedge clk) disable iff (rst)
      done && timing.acquireTimeSel == 3'h0);
   c_auto: cover property (@(posedge clk) disable iff (rst)
      done && timing.acquireTimeSel == 3'h7);
   c_abort: cover property (@(posedge clk) disable iff (rst)
      state == sar_adc_pkg::ST_CONVERT && !startBusy);
   c_rc_done: cover property (@(posedge clk) disable iff (rst)
      done && isRc);
   c_start_refused: cover property (@(posedge clk) disable iff (rst)
      writeMain && wb_dat_i[sar_adc_pkg::START_BIT]
      && !wb_dat_i[sar_adc_pkg::ENABLE_BIT]);
endmodule

// ===== tb/sar_comparator_model.sv
// comparator and holding capacitor model facing the sar sequencer
`timescale 1ns/100ps
module sar_comparator_model (
   input wire logic clk,
   input wire logic sampleSwitch,
   input wire logic [9:0] inputLevel,
   input wire logic [9:0] trialCode,
   output logic compareHigh
);
   // ---------------------------------------------
   // holding capacitor
   // ---------------------------------------------
   logic [9:0] held;
   // tracks the input only while the switch is closed
   always_ff @(posedge clk) begin
      if (sampleSwitch) begin
         held <= inputLevel;
      end
   end
   // ---------------------------------------------
   // comparator
   // ---------------------------------------------
   assign compareHigh = trialCode <= held;
endmodule

// ===== tb/tb_sar_adc_sequencer.sv
// testbench: register and conversion tests of the sar sequencer
`timescale 1ns/100ps
`define CHK(n, e, s) begin nTests++; if ((s) !== (e)) begin errCount++; \
   $display("mismatch %s expected %h seen %h", n, e, s); end end
module tb_sar_adc_sequencer;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   localparam logic [9:0] LVL = 10'h2a5;
   localparam logic [3:0] MAIN = sar_adc_pkg::MAIN_CTRL_ADDR;
   localparam logic [3:0] TIM = sar_adc_pkg::TIMING_CTRL_ADDR;
   localparam logic [3:0] HIGH = sar_adc_pkg::RESULT_HIGH_ADDR;
   localparam logic [3:0] LOW = sar_adc_pkg::RESULT_LOW_ADDR;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'h1;
   logic [31:0] rdat;
   logic ack;
   logic cmpHigh;
   logic sampleSwitch;
   logic [9:0] trialCode;
   logic powered;
   logic flag;
   logic [9:0] level = LVL;
   int errCount = 0;
   int nTests = 0;
   int cycle = 0;
   int divTab[8] = '{2, 8, 32, 4, 4, 16, 64, 4};
   int tickTab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   always #4 clk = ~clk;
   always @(posedge clk) cycle <= cycle + 1;
   // ---------------------------------------------
   // design and far side
   // ---------------------------------------------
   sar_adc_sequencer #(.RC_DIV(4)) u_sar_adc_sequencer (
      .clk(clk), .rst(rst), .wb_cyc_i(req), .wb_stb_i(req),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .compareHigh(cmpHigh),
      .sampleSwitch(sampleSwitch), .trialCode(trialCode),
      .converterPowered(powered), .conversionDoneFlag(flag)
   );
   sar_comparator_model u_sar_comparator_model (
      .clk(clk), .sampleSwitch(sampleSwitch), .inputLevel(level),
      .trialCode(trialCode), .compareHigh(cmpHigh)
   );
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic endOfTest;
      if (errCount == 0 && nTests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = rdat[7:0];
      req <= 1'b0;
   endtask
   function automatic bit near(int v, int e, int d);
      return v >= e - 2 && v <= e + d + 2;
   endfunction
   // one full conversion, input moved while the capacitor holds
   task automatic conv(input logic [7:0] tim, input int d, input int t);
      logic [7:0] q;
      int c0;
      int e;
      // four cycles from commit: leave idle, tick pipe, flag
      e = d * (t + 11) + 4
         + ((tim[1:0] == 2'b11) ? sar_adc_pkg::RC_START_DELAY : 0);
      wb(1'b1, MAIN, 8'h01, q);
      repeat (3 * d) @(posedge clk);
      wb(1'b1, TIM, tim, q);
      wb(1'b1, MAIN, 8'h03, q);
      c0 = cycle;
      while (sampleSwitch !== 1'b0) @(posedge clk);
      level <= ~LVL;
      wb(1'b0, MAIN, 8'h00, q);
      `CHK("busy", 8'h03, q)
      while (flag !== 1'b1) @(posedge clk);
      `CHK("duration", 1'b1, near(cycle - c0, e, d))
      `CHK("resample", 1'b1, sampleSwitch)
      level <= LVL;
      wb(1'b0, MAIN, 8'h00, q);
      `CHK("done", 8'h81, q)
      wb(1'b0, HIGH, 8'h00, q);
      `CHK("high", tim[7] ? {6'h0, LVL[9:8]} : LVL[9:2], q)
      wb(1'b0, LOW, 8'h00, q);
      `CHK("low", tim[7] ? LVL[7:0] : {LVL[1:0], 6'h0}, q)
   endtask
   // ---------------------------------------------
   // watchdog
   // ---------------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      errCount++;
      endOfTest;
   end
   // ---------------------------------------------
   // test sequence
   // ---------------------------------------------
   initial begin
      logic [7:0] q;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      wb(1'b0, MAIN, 8'h00, q);
      `CHK("main reset", 8'h00, q)
      wb(1'b0, TIM, 8'h00, q);
      `CHK("timing reset", 8'h00, q)
      `CHK("powered reset", 1'b0, powered)
      wb(1'b1, TIM, 8'hff, q);
      wb(1'b0, TIM, 8'h00, q);
      `CHK("timing bits", 8'hbf, q)
      sel <= 4'h0;
      wb(1'b1, TIM, 8'h00, q);
      sel <= 4'h1;
      wb(1'b0, TIM, 8'h00, q);
      `CHK("lane off", 8'hbf, q)
      wb(1'b0, 4'h2, 8'h00, q);
      `CHK("unmapped", 8'h00, q)
      for (int c = 0; c < 8; c++) begin
         conv({c[0], 4'h0, c[2:0]}, divTab[c], 0);
      end
      `CHK("powered", 1'b1, powered)
      for (int a = 1; a < 8; a++) begin
         conv({2'b10, a[2:0], 3'b001}, 8, tickTab[a]);
      end
      wb(1'b1, TIM, 8'h86, q);
      wb(1'b1, MAIN, 8'h03, q);
      repeat (100) @(posedge clk);
      wb(1'b1, MAIN, 8'h01, q);
      wb(1'b0, MAIN, 8'h00, q);
      `CHK("abort", 8'h01, q)
      wb(1'b0, HIGH, 8'h00, q);
      `CHK("abort high", 8'h02, q)
      wb(1'b0, LOW, 8'h00, q);
      `CHK("abort low", 8'ha5, q)
      wb(1'b1, MAIN, 8'h00, q);
      wb(1'b1, MAIN, 8'h02, q);
      repeat (40) @(posedge clk);
      wb(1'b0, MAIN, 8'h00, q);
      `CHK("start off", 8'h00, q)
      `CHK("flag off", 1'b0, flag)
      wb(1'b1, MAIN, 8'h03, q);
      repeat (50) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      `CHK("switch reset", 1'b0, sampleSwitch)
      wb(1'b0, MAIN, 8'h00, q);
      `CHK("main rereset", 8'h00, q)
      wb(1'b0, TIM, 8'h00, q);
      `CHK("timing rereset", 8'h00, q)
      wb(1'b0, HIGH, 8'h00, q);
      `CHK("result kept", {6'h0, LVL[9:8]}, q)
      `CHK("flag rereset", 1'b0, flag)
      endOfTest;
   end
endmodule
